/* File: shared/tfp_consts.vh */
/*
 * Constants for the 16-bit timer waveform generator: mode codes,
 * fixed top values, compare output mode codes and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef TFP_CONSTS_VH
`define TFP_CONSTS_VH

// ********************************
// Waveform mode select codes
// ********************************
`define TFP_MODE_PC8 4'h1
`define TFP_MODE_PC9 4'h2
`define TFP_MODE_PC10 4'h3
`define TFP_MODE_FP8 4'h5
`define TFP_MODE_FP9 4'h6
`define TFP_MODE_FP10 4'h7
`define TFP_MODE_PC_CAP 4'hA
`define TFP_MODE_PC_CMPA 4'hB
`define TFP_MODE_FP_CAP 4'hE
`define TFP_MODE_FP_CMPA 4'hF

// ********************************
// Counter values
// ********************************
`define TFP_TOP_8BIT 16'h00FF
`define TFP_TOP_9BIT 16'h01FF
`define TFP_TOP_10BIT 16'h03FF
`define TFP_CNT_MAX 16'hFFFF
`define TFP_BOTTOM 16'h0000
`define TFP_STEP 16'h0001

// ********************************
// Compare output mode codes
// ********************************
`define TFP_COM_OFF 2'h0
`define TFP_COM_TOGGLE 2'h1
`define TFP_COM_NONINV 2'h2
`define TFP_COM_INV 2'h3

// ********************************
// Reset values
// ********************************
`define TFP_RST_CNT 16'h0000
`define TFP_RST_CMP 16'h0000
`define TFP_RST_FLAG 1'b0
`define TFP_RST_OC 1'b0
`define TFP_RST_UP 1'b1

`endif

/* File: src/tfp_channel.v */
/*
 * One compare channel: buffered and active compare value, the internal
 * compare output level and the pin override.
 * Assumes the counter, tick and top events come from the timer core on
 * the same clock.
 */
`include "tfp_consts.vh"

module tfp_channel #(
	parameter W = 16,
	parameter TOGGLE_EN = 1'b0
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Core timing
	input wire tick_i,
	input wire fast_i,
	input wire phase_i,
	input wire up_i,
	input wire at_top_i,
	input wire top_evt_i,
	input wire [W-1:0] cnt_i,
	// Compare value access
	input wire wr_i,
	input wire [W-1:0] wdata_i,
	input wire direct_i,
	// Output control
	input wire [1:0] com_i,
	input wire port_val_i,
	input wire pin_dir_i,
	// Results
	output wire match_o,
	output wire [W-1:0] act_o,
	output reg pin_o,
	output reg pin_oe_o
);

	reg [W-1:0] buf_r; // Written value, waits for top
	reg [W-1:0] act_r; // Value the counter is compared with
	reg oc_r; // Internal compare output level
	wire clr_side; // Match that acts like the rising slope

	assign match_o = (cnt_i == act_r);
	assign act_o = act_r;
	// Bottom counts as up-slope and top as down-slope, so 0 and top give
	// steady levels in dual-slope mode
	assign clr_side = (cnt_i == `TFP_BOTTOM) | (up_i & ~at_top_i);

	// ********************************
	// Compare value buffering
	// ********************************
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			buf_r <= `TFP_RST_CMP;
			act_r <= `TFP_RST_CMP;
		end
		else
		begin
			// Writes always land in the buffer
			if (wr_i)
				buf_r <= wdata_i;
			// Non-PWM modes see the value at once
			if (wr_i & direct_i)
				act_r <= wdata_i;
			else if (top_evt_i)
				act_r <= buf_r;
		end
	end

	// ********************************
	// Compare output level
	// ********************************
	always @(posedge clk_i)
	begin
		if (rst_i)
			oc_r <= `TFP_RST_OC;
		else if (tick_i)
		begin
			if (com_i == `TFP_COM_TOGGLE)
			begin
				// Toggle on each match in fast or dual-slope mode, channel A only; 50% duty in fast mode
				if (TOGGLE_EN && (fast_i | phase_i) && match_o)
					oc_r <= ~oc_r;
			end
			else if (com_i != `TFP_COM_OFF)
			begin
				if (fast_i)
				begin
					// Bottom action wins, so compare equal top is steady
					if (top_evt_i)
						oc_r <= (com_i == `TFP_COM_NONINV);
					else if (match_o)
						oc_r <= (com_i == `TFP_COM_INV);
				end
				else if (phase_i && match_o)
				begin
					if (clr_side)
						oc_r <= (com_i == `TFP_COM_INV);
					else
						oc_r <= (com_i == `TFP_COM_NONINV);
				end
			end
		end
	end

	// ********************************
	// Pin override, registered
	// ********************************
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_o <= `TFP_RST_OC;
			pin_oe_o <= `TFP_RST_OC;
		end
		else
		begin
			pin_o <= (com_i != `TFP_COM_OFF) ? oc_r : port_val_i;
			pin_oe_o <= pin_dir_i;
		end
	end

endmodule

/* File: src/tfp_pwm.v */
/*
 * 16-bit timer waveform generator with single-slope and dual-slope
 * PWM, two compare channels and the overflow, compare and capture flags.
 * Assumes a prescaler supplies a one-cycle tick enable and that software
 * logic on the same clock drives the configuration and write strobes.
 */
// Operation
// - Modes 5,6,7,14,15 count single-slope upward
// - Fast top fixed, capture or compare A
// - Non-inverted clears on match, sets at bottom
// - Output mode two normal, three inverted
// - Fast mode sets overflow at top
// - Top source flag set with overflow
// - Fixed top masks upper compare bits
// - Capture top is unbuffered, may wrap
// - Compare A buffered, loads at top
// - Counter equal compare sets channel flag
// - Pin driven only when direction is output
// - Compare zero spikes, compare top steady
// - Output mode one toggles channel A
// - Period is top plus one ticks
// - Programmable top spans two to sixteen bits
// - Modes 1,2,3,10,11 count dual-slope
// - Dual top fixed, capture or compare A
// - Dual clears up-match, sets down-match
// - Dual mode sets overflow at bottom
// - Dual loads buffers and flags at top
// - Output mode zero leaves output alone
// - Nonzero output mode overrides port value
`include "tfp_consts.vh"

module tfp_pwm #(
	parameter W = 16,
	parameter NCH = 2
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Prescaler
	input wire tick_i,
	// Configuration
	input wire [3:0] waveform_mode_select_i,
	input wire [1:0] compare_output_mode_a_i,
	input wire [1:0] compare_output_mode_b_i,
	input wire [W-1:0] capture_value_i,
	// Compare value writes
	input wire compare_value_a_wr_i,
	input wire compare_value_b_wr_i,
	input wire [W-1:0] compare_value_wdata_i,
	// Flag clears, one bit per flag
	input wire overflow_flag_clr_i,
	input wire compare_flag_a_clr_i,
	input wire compare_flag_b_clr_i,
	input wire capture_flag_clr_i,
	// Port pins
	input wire port_value_a_i,
	input wire port_value_b_i,
	input wire pin_direction_bit_a_i,
	input wire pin_direction_bit_b_i,
	// Status
	output wire [W-1:0] counter_value_o,
	output reg overflow_flag_o,
	output reg compare_flag_a_o,
	output reg compare_flag_b_o,
	output reg capture_flag_o,
	// Pins
	output wire compare_output_a_o,
	output wire compare_output_a_oe_o,
	output wire compare_output_b_o,
	output wire compare_output_b_oe_o
);

	// ********************************
	// Mode decoding
	// ********************************

	// Single-slope PWM modes
	function is_fast;
		input [3:0] m;
		begin
			is_fast = (m == `TFP_MODE_FP8) | (m == `TFP_MODE_FP9) |
				(m == `TFP_MODE_FP10) | (m == `TFP_MODE_FP_CAP) |
				(m == `TFP_MODE_FP_CMPA);
		end
	endfunction

	// Dual-slope PWM modes
	function is_phase;
		input [3:0] m;
		begin
			is_phase = (m == `TFP_MODE_PC8) | (m == `TFP_MODE_PC9) |
				(m == `TFP_MODE_PC10) | (m == `TFP_MODE_PC_CAP) |
				(m == `TFP_MODE_PC_CMPA);
		end
	endfunction

	// Fixed top of the mode, all ones when the mode has none
	function [W-1:0] fixed_top;
		input [3:0] m;
		begin
			case (m)
				`TFP_MODE_FP8, `TFP_MODE_PC8:
					fixed_top = `TFP_TOP_8BIT;
				`TFP_MODE_FP9, `TFP_MODE_PC9:
					fixed_top = `TFP_TOP_9BIT;
				`TFP_MODE_FP10, `TFP_MODE_PC10:
					fixed_top = `TFP_TOP_10BIT;
				default:
					fixed_top = `TFP_CNT_MAX;
			endcase
		end
	endfunction

	// ********************************
	// Declarations
	// ********************************
	reg [W-1:0] cnt_r; // Counter value
	reg up_r; // Counting direction, high while counting up
	reg [W-1:0] top_w; // Current top value
	wire fast_w; // Single-slope mode active
	wire phase_w; // Dual-slope mode active
	wire top_a_w; // Compare A defines top
	wire top_cap_w; // Capture value defines top
	wire at_top_w; // Counter equals top
	wire top_evt_w; // Tick on which top is taken
	wire ovf_set_w; // Overflow flag set event
	wire [W-1:0] wmask_w; // Mask applied to compare writes
	wire [W-1:0] wdata_w; // Masked compare write data
	wire [NCH-1:0] match_w; // Per-channel match
	wire [NCH*W-1:0] act_w; // Per-channel active compare values
	wire [NCH-1:0] wr_w; // Per-channel write strobes
	wire [2*NCH-1:0] com_w; // Per-channel output modes
	wire [NCH-1:0] port_w; // Per-channel port values
	wire [NCH-1:0] dir_w; // Per-channel pin direction bits
	wire [NCH-1:0] pin_w; // Per-channel pin levels
	wire [NCH-1:0] oe_w; // Per-channel pin enables

	assign fast_w = is_fast(waveform_mode_select_i);
	assign phase_w = is_phase(waveform_mode_select_i);
	assign top_a_w = (waveform_mode_select_i == `TFP_MODE_FP_CMPA) |
		(waveform_mode_select_i == `TFP_MODE_PC_CMPA);
	assign top_cap_w = (waveform_mode_select_i == `TFP_MODE_FP_CAP) |
		(waveform_mode_select_i == `TFP_MODE_PC_CAP);

	// ********************************
	// Top selection
	// ********************************

	// Capture top is read straight from the port: no buffer, so a value
	// written below the count is missed until the counter wraps
	always @*
	begin
		if (top_cap_w)
			top_w = capture_value_i;
		else if (top_a_w)
			top_w = act_w[W-1:0];
		else
			top_w = fixed_top(waveform_mode_select_i);
	end

	assign at_top_w = (cnt_r == top_w);
	// Fast mode takes top while clearing; dual mode on the turn at top
	assign top_evt_w = tick_i & at_top_w & (fast_w | (phase_w & up_r));

	// Unused upper bits drop out on any compare write in fixed modes
	assign wmask_w = fixed_top(waveform_mode_select_i);
	assign wdata_w = compare_value_wdata_i & wmask_w;

	// ********************************
	// Counter
	// ********************************

	// Period in fast mode is top plus one ticks; the tick itself carries
	// the prescaler division
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_r <= `TFP_RST_CNT;
			up_r <= `TFP_RST_UP;
		end
		else if (tick_i)
		begin
			if (fast_w)
			begin
				// Restart from bottom on the tick after top
				up_r <= 1'b1;
				if (at_top_w)
					cnt_r <= `TFP_BOTTOM;
				else
					cnt_r <= cnt_r + `TFP_STEP;
			end
			else if (phase_w)
			begin
				if (up_r)
				begin
					// Top stands for one tick, then the count falls
					if (at_top_w)
					begin
						up_r <= 1'b0;
						cnt_r <= cnt_r - `TFP_STEP;
					end
					else
						cnt_r <= cnt_r + `TFP_STEP;
				end
				else
				begin
					// Turn at bottom
					if (cnt_r == `TFP_BOTTOM)
					begin
						up_r <= 1'b1;
						cnt_r <= cnt_r + `TFP_STEP;
					end
					else
						cnt_r <= cnt_r - `TFP_STEP;
				end
			end
			else
			begin
				// Other modes are outside this block: free-running up count
				up_r <= 1'b1;
				cnt_r <= cnt_r + `TFP_STEP;
			end
		end
	end

	assign counter_value_o = cnt_r;

	// ********************************
	// Flags
	// ********************************

	// Overflow: top in fast mode, bottom in dual mode, wrap otherwise
	assign ovf_set_w = tick_i & (fast_w ? at_top_w :
		phase_w ? (~up_r & (cnt_r == `TFP_BOTTOM)) :
		(cnt_r == `TFP_CNT_MAX));

	// A set arriving with a clear wins, so no event is lost
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			overflow_flag_o <= `TFP_RST_FLAG;
			compare_flag_a_o <= `TFP_RST_FLAG;
			compare_flag_b_o <= `TFP_RST_FLAG;
			capture_flag_o <= `TFP_RST_FLAG;
		end
		else
		begin
			overflow_flag_o <= (overflow_flag_o & ~overflow_flag_clr_i) | ovf_set_w;
			// Compare A also flags top when it defines top
			compare_flag_a_o <= (compare_flag_a_o & ~compare_flag_a_clr_i) |
				(tick_i & match_w[0]) | (top_evt_w & top_a_w);
			compare_flag_b_o <= (compare_flag_b_o & ~compare_flag_b_clr_i) |
				(tick_i & match_w[1]);
			capture_flag_o <= (capture_flag_o & ~capture_flag_clr_i) |
				(top_evt_w & top_cap_w);
		end
	end

	// ********************************
	// Compare channels
	// ********************************

	// Gather per-channel controls so one loop builds both channels
	assign wr_w = {compare_value_b_wr_i, compare_value_a_wr_i};
	assign com_w = {compare_output_mode_b_i, compare_output_mode_a_i};
	assign port_w = {port_value_b_i, port_value_a_i};
	assign dir_w = {pin_direction_bit_b_i, pin_direction_bit_a_i};

	// Only channel A may toggle; a compare above top never matches,
	// which software must avoid
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : ch
			tfp_channel #(
				.W(W),
				.TOGGLE_EN((g == 0) ? 1'b1 : 1'b0)
			) u_chan (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.tick_i(tick_i),
				.fast_i(fast_w),
				.phase_i(phase_w),
				.up_i(up_r),
				.at_top_i(at_top_w),
				.top_evt_i(top_evt_w),
				.cnt_i(cnt_r),
				.wr_i(wr_w[g]),
				.wdata_i(wdata_w),
				.direct_i(~(fast_w | phase_w)),
				.com_i(com_w[2*g+1:2*g]),
				.port_val_i(port_w[g]),
				.pin_dir_i(dir_w[g]),
				.match_o(match_w[g]),
				.act_o(act_w[W*g+W-1:W*g]),
				.pin_o(pin_w[g]),
				.pin_oe_o(oe_w[g])
			);
		end
	endgenerate

	// ********************************
	// Pin outputs, registered in the channels
	// ********************************
	assign compare_output_a_o = pin_w[0];
	assign compare_output_a_oe_o = oe_w[0];
	assign compare_output_b_o = pin_w[1];
	assign compare_output_b_oe_o = oe_w[1];

endmodule

/* File: verif/tfp_pwm_asserts.sv */
/* Checker for the tfp_pwm counter, flag and pin timing.
 * Assumes it is bound to tfp_pwm and sees only that module's ports. */
module tfp_pwm_asserts #(
	parameter W = 16
) (
	// Clock, reset and controls
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire [3:0] waveform_mode_select_i,
	input wire [1:0] compare_output_mode_a_i,
	input wire [W-1:0] capture_value_i,
	input wire port_value_a_i,
	input wire pin_direction_bit_a_i,
	// Watched outputs
	input wire [W-1:0] counter_value_o,
	input wire overflow_flag_o,
	input wire capture_flag_o,
	input wire compare_output_a_o,
	input wire compare_output_a_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Short aliases keep the properties on one line
	wire [3:0] m = waveform_mode_select_i;
	wire [W-1:0] c = counter_value_o;
	// Dual descent reaching bottom, then a tick there
	sequence s_bottom;
		tick_i && m == 4'h1 && c == 16'h0001 ##1 tick_i && c == 16'h0000;
	endsequence
	// Fast tick sitting on the capture top
	sequence s_cap_top;
		tick_i && m == 4'hE && c == capture_value_i;
	endsequence
	cnt_hold_a: assert property
		(!tick_i |=> $stable(c))
		else $error("count moved without tick");
	fast_step_a: assert property
		(tick_i && m == 4'h5 && c != 16'h00FF |=> c == $past(c) + 16'h0001)
		else $error("fast count did not step");
	fast_wrap_a: assert property
		(tick_i && m == 4'h5 && c == 16'h00FF |=> c == 16'h0000)
		else $error("fast count did not wrap");
	cap_top_a: assert property
		(s_cap_top |=> overflow_flag_o && capture_flag_o && c == 16'h0000)
		else $error("capture top flags wrong");
	dual_turn_a: assert property
		(tick_i && m == 4'h1 && c == 16'h00FF |=> c == 16'h00FE)
		else $error("dual count did not turn");
	dual_bottom_a: assert property
		(s_bottom |=> overflow_flag_o && c == 16'h0001)
		else $error("dual bottom overflow missing");
	pin_dir_a: assert property
		(1'h1 |=> compare_output_a_oe_o == $past(pin_direction_bit_a_i))
		else $error("pin enable wrong");
	port_pass_a: assert property
		(compare_output_mode_a_i == 2'h0 |=> compare_output_a_o == $past(port_value_a_i))
		else $error("port value not passed");
endmodule

bind tfp_pwm tfp_pwm_asserts #(.W(W)) tfp_pwm_asserts_inst (.clk_i, .rst_i, .tick_i,
	.waveform_mode_select_i, .compare_output_mode_a_i, .capture_value_i, .port_value_a_i,
	.pin_direction_bit_a_i, .counter_value_o, .overflow_flag_o, .capture_flag_o,
	.compare_output_a_o, .compare_output_a_oe_o);

/* File: verif/tb_top.sv */
/* Bench for tfp_pwm: a cycle model of counter, flags and both pins queues
 * expectations that a monitor compares. Assumes one clock, sync reset. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ********************
	// Stimulus and model
	// ********************
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic tick = 1'h0;
	logic full = 1'h0;
	logic wr = 1'h0;
	logic wpend = 1'h0;
	logic port = 1'h0;
	logic dir = 1'h0;
	logic [2:0] clr = 3'h0;
	logic clrb = 1'h0;
	logic portb = 1'h0;
	logic dirb = 1'h0;
	logic [1:0] com = 2'h0;
	logic [3:0] mode = 4'h0;
	logic [15:0] cap = 16'h0040;
	logic [15:0] wd = 16'h0000;
	logic [31:0] seed = 32'h000118A7;
	wire [15:0] cnt;
	wire [7:0] fl;
	// Channel B shares the compare writes but flips bit 0 of the output mode: opposite polarity for modes two and three
	wire [1:0] comb = com ^ 2'h1;
	logic [15:0] m_cnt, m_act, m_buf, top;
	logic m_up, m_oc, m_ovf, m_cfa, m_cap, m_pin, m_oe, ev, mt, dual, pwm;
	logic m_ocb, m_cfb, m_pinb, m_oeb;
	logic [23:0] q[$];
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	// Mode, output mode, compare value: extremes, masking, every PWM mode
	// Every compare value stays at or below its top
	logic [21:0] tab [10] = '{{4'h5, 2'h2, 16'hFF80}, {4'h6, 2'h3, 16'h0000},
		{4'h7, 2'h2, 16'h03FF}, {4'hE, 2'h2, 16'h0005}, {4'hF, 2'h1, 16'h0003},
		{4'h1, 2'h2, 16'h0040}, {4'h2, 2'h3, 16'h0000}, {4'h3, 2'h2, 16'h03FF},
		{4'hA, 2'h0, 16'h0020}, {4'hB, 2'h1, 16'h0007}};
	always #4 clk_i = ~clk_i;
	tfp_pwm tfp_pwm_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tick),
		.waveform_mode_select_i(mode),
		.compare_output_mode_a_i(com),
		.compare_output_mode_b_i(comb),
		.capture_value_i(cap),
		.compare_value_a_wr_i(wr),
		.compare_value_b_wr_i(wr),
		.compare_value_wdata_i(wd),
		.overflow_flag_clr_i(clr[0]),
		.compare_flag_a_clr_i(clr[1]),
		.compare_flag_b_clr_i(clrb),
		.capture_flag_clr_i(clr[2]),
		.port_value_a_i(port),
		.port_value_b_i(portb),
		.pin_direction_bit_a_i(dir),
		.pin_direction_bit_b_i(dirb),
		.counter_value_o(cnt),
		.overflow_flag_o(fl[7]),
		.compare_flag_a_o(fl[6]),
		.compare_flag_b_o(fl[2]),
		.capture_flag_o(fl[5]),
		.compare_output_a_o(fl[4]),
		.compare_output_a_oe_o(fl[3]),
		.compare_output_b_o(fl[1]),
		.compare_output_b_oe_o(fl[0])
	);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// Next internal output level of one channel on a tick; tg allows toggling
	function automatic logic oc_nx(input logic oc, input logic [1:0] c, input logic tg);
		if (pwm && c == 2'h1 && mt)
			return oc ^ tg;
		if (c[1] && ev && !dual)
			return ~c[0];
		if (pwm && c[1] && mt)
			return c[0] ^ (dual && (m_cnt == top || (m_cnt != 16'h0000 && !m_up)));
		return oc;
	endfunction
	// One edge of the model, using the inputs sampled at that edge
	task step;
		dual = mode inside {4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
		pwm = dual || mode inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
		case (mode)
			4'h1, 4'h5: top = 16'h00FF;
			4'h2, 4'h6: top = 16'h01FF;
			4'h3, 4'h7: top = 16'h03FF;
			4'hA, 4'hE: top = cap;
			default: top = m_act;
		endcase
		// Pin is registered from the level held before this edge
		m_pin = (com != 2'h0) ? m_oc : port;
		m_oe = dir;
		m_pinb = (comb != 2'h0) ? m_ocb : portb;
		m_oeb = dirb;
		if (rst_i)
		begin
			{m_cnt, m_act, m_buf} = 48'h0;
			{m_up, m_oc, m_ovf, m_cfa, m_cap, m_pin, m_oe, m_ocb, m_cfb, m_pinb, m_oeb} = 11'h400;
		end
		else
		begin
			// Clears first, so a set on the same edge wins
			{m_cap, m_cfa, m_ovf} = {m_cap, m_cfa, m_ovf} & ~clr;
			m_cfb = m_cfb & ~clrb;
			if (tick)
			begin
				mt = m_cnt == m_act;
				ev = pwm && m_cnt == top && (!dual || m_up);
				m_cfa = m_cfa | mt;
				m_cfb = m_cfb | mt;
				// Toggle acts on channel A only
				m_oc = oc_nx(m_oc, com, 1'h1);
				m_ocb = oc_nx(m_ocb, comb, 1'h0);
				if (dual && ev)
					m_up = 1'h0;
				else if (dual && m_cnt == 16'h0000 && !m_up)
				begin
					m_up = 1'h1;
					m_ovf = 1'h1;
				end
				m_ovf = m_ovf | (ev && !dual);
				m_cnt = (ev && !dual) ? 16'h0000 : (m_up ? m_cnt + 16'h0001 : m_cnt - 16'h0001);
				if (ev)
				begin
					m_act = m_buf;
					m_cap = m_cap | (mode == 4'hA || mode == 4'hE);
				end
			end
			if (wr)
				m_buf = (mode[3] || mode[1:0] == 2'h0) ? wd : wd & top;
			if (wr && !pwm)
				m_act = m_buf;
		end
		q.push_back({m_cnt, m_ovf, m_cfa, m_cap, m_pin, m_oe, m_cfb, m_pinb, m_oeb});
	endtask
	// Model the edge, then drive fresh random inputs
	task run(input int n);
		repeat (n)
		begin
			@(posedge clk_i);
			#1;
			step();
			seed = xs(seed);
			tick = full | (seed[2:0] != 3'h0);
			{dir, port, clr} = seed[7:3];
			{dirb, portb, clrb} = seed[10:8];
			wr = wpend;
			wpend = 1'h0;
		end
	endtask
	task check(input logic [23:0] e);
		n_tests++;
		if ({cnt, fl} !== e)
		begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, {cnt, fl}, e);
		end
	endtask
	task final_report;
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Monitor: oldest note against the settled outputs
	always @(posedge clk_i)
	begin
		#2;
		if (q.size() != 0)
			check(q.pop_front());
	end
	// Hang guard
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			error_cnt++;
			final_report();
		end
	end
	initial
	begin
		run(20);
		for (int i = 0; i < 10; i++)
		begin
			// Dual compare-A top (mode 11) is preloaded in a free-run mode to avoid a zero top
			rst_i = 1'h1;
			mode = (tab[i][21:18] == 4'hB) ? 4'h0 : tab[i][21:18];
			{com, wd} = tab[i][17:0];
			run(1);
			wpend = 1'h1;
			run(1);
			rst_i = 1'h0;
			run(1);
			mode = tab[i][21:18];
			run(2400);
		end
		// Capture top lowered below the count forces a full wrap
		rst_i = 1'h1;
		mode = 4'hE;
		com = 2'h2;
		full = 1'h1;
		run(2);
		rst_i = 1'h0;
		run(48);
		cap = 16'h0010;
		run(65600);
		final_report();
	end
endmodule
